// [verif/ebm_dma_partner.sv]
`timescale 1ns/1ps
`default_nettype none
// Behavioural DMA controller sitting on the buffer manager's DMA pins.
module ebm_dma_partner (
   // Clock and reset.
   input wire logic core_clk,
   input wire logic rst_b,
   // Control from the bench.
   input wire logic run,
   input wire logic slow,
   // DMA pins.
   input wire logic dma_req,
   output logic dma_ack_b,
   output logic [7:0] dma_wdata,
   input wire logic [7:0] dma_rdata,
   // Progress seen by the bench.
   output var int cnt,
   output logic [7:0] last_rd
);
   // One acknowledge pulse per byte; data stands 3 cycles (6 when slow) before the pulse and 3 after it.
   initial begin
      dma_ack_b = 1'b1;
      dma_wdata = 8'h5a;
      cnt = 0;
      last_rd = 8'h00;
      forever begin
         @(posedge core_clk);
         if (run && rst_b && dma_req === 1'b1) begin
            dma_wdata <= 8'h80 + cnt[7:0];
            repeat (slow ? 6 : 3) @(posedge core_clk);
            dma_ack_b <= 1'b0;
            // Long enough for the two-stage synchroniser and the read data.
            repeat (6) @(posedge core_clk);
            last_rd = dma_rdata;
            dma_ack_b <= 1'b1;
            cnt = cnt + 1;
            repeat (3) @(posedge core_clk);
            // Released data is scrambled so that a late sample shows up.
            dma_wdata <= ~dma_wdata;
         end
      end
   end
endmodule // ebm_dma_partner
`default_nettype wire

// [verif/tb_usb_endpoint_buffer_manager.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_usb_endpoint_buffer_manager
   import ebm_pkg::*;
;
   // Register rows: address, write value, read-back value, error expected.
   typedef struct packed {logic [7:0] a; logic [7:0] d; logic [7:0] x; logic e;} ebm_row_t;
   ebm_row_t rows [7] = '{'{CLKDIV_OFS, 8'h80, 8'h80, 1'b0}, '{DMACFG_OFS, 8'h20, 8'h20, 1'b0},
      '{PMODE_OFS, 8'h03, 8'h03, 1'b0}, '{PMODE_OFS, 8'h00, 8'h00, 1'b0}, '{8'h1c, 8'h55, 8'h00, 1'b1},
      '{CLKDIV_OFS, 8'h00, 8'h00, 1'b0}, '{DMACFG_OFS, 8'h00, 8'h00, 1'b0}};
   logic core_clk, rst_b, psel, penable, pwrite, pready, pslverr;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rdv;
   logic erv, usb_out_valid, usb_out_last, usb_out_ready, usb_in_req, usb_in_valid, usb_in_last;
   logic [2:0] usb_out_idx, usb_in_idx;
   logic [7:0] usb_out_data, usb_in_data, dma_wdata, dma_rdata, last_rd;
   logic usb_in_ready, usb_in_nak, usb_sof, dma_req, dma_ack_b, int_b_o, int_b_oe, run, slow;
   int cnt, fail_count, cmp_count;
   int cyc = 0;
   ebm_buffer_mgr dut (.core_clk, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
      .pslverr, .usb_out_valid, .usb_out_idx, .usb_out_data, .usb_out_last, .usb_out_ready, .usb_in_req,
      .usb_in_idx, .usb_in_valid, .usb_in_data, .usb_in_last, .usb_in_ready, .usb_in_nak, .usb_sof,
      .dma_req, .dma_ack_b, .dma_wdata, .dma_rdata, .int_b_o, .int_b_oe);
   ebm_dma_partner dma (.core_clk, .rst_b, .run, .slow, .dma_req, .dma_ack_b, .dma_wdata, .dma_rdata,
      .cnt, .last_rd);
   ////////////////////////////////////////////////////////////////////////
   // Clock and a watchdog that cuts a hang short.
   always #50 core_clk = ~core_clk;
   always @(posedge core_clk) begin
      cyc++;
      if (cyc == 20000) begin
         fail_count++;
         final_report();
      end
   end
   ////////////////////////////////////////////////////////////////////////
   // Compare one value and count it.
   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         fail_count++;
         $display("ERROR %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // Prints the counts and the verdict, then stops.
   task automatic final_report();
      $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   // One APB transfer; the request stands until pready is sampled high.
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      do @(posedge core_clk); while (pready !== 1'b1);
      rdv = prdata;
      erv = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge core_clk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   task automatic rd(input logic [7:0] a);
      apb(1'b0, a, 32'h0);
   endtask
   // Host OUT packet of n bytes counting up from b.
   task automatic usb_send(input logic [2:0] ix, input int n, input logic [7:0] b);
      for (int i = 0; i < n; i++) begin
         usb_out_valid <= 1'b1;
         usb_out_idx <= ix;
         usb_out_data <= b + i[7:0];
         usb_out_last <= (i == n - 1);
         do @(posedge core_clk); while (usb_out_ready !== 1'b1);
      end
      usb_out_valid <= 1'b0;
      @(posedge core_clk);
   endtask
   // Host IN request; the host stalls two cycles before taking bytes.
   task automatic in_get(input logic [2:0] ix, input int n, input logic [7:0] b, input logic nk);
      usb_in_req <= 1'b1;
      usb_in_idx <= ix;
      usb_in_ready <= 1'b0;
      @(posedge core_clk);
      usb_in_req <= 1'b0;
      @(posedge core_clk);
      check("in nak", usb_in_nak, nk);
      repeat (2) @(posedge core_clk);
      usb_in_ready <= 1'b1;
      for (int i = 0; i < n; i++) begin
         do @(posedge core_clk); while (usb_in_valid !== 1'b1);
         check("in byte", {usb_in_last, usb_in_data}, {i == n - 1, b + i[7:0]});
      end
   endtask
   task automatic do_reset();
      rst_b <= 1'b0;
      repeat (5) @(posedge core_clk);
      rst_b <= 1'b1;
      @(posedge core_clk);
   endtask
   ////////////////////////////////////////////////////////////////////////
   // Main sequence.
   initial begin
      {core_clk, psel, penable, pwrite, paddr, pwdata, usb_out_valid, usb_out_idx, usb_out_data} = '0;
      {usb_out_last, usb_in_req, usb_in_idx, usb_sof, run, slow, rst_b} = '0;
      {fail_count, cmp_count} = '0;
      usb_in_ready = 1'b1;
      do_reset();
      check("ready rst", usb_out_ready, 1);
      check("oe rst", {int_b_o, int_b_oe, dma_req}, 0);
      rd(CLKDIV_OFS); check("clkdiv rst", rdv[7:0], CLKDIV_RST);
      rd(DMACFG_OFS); check("dmacfg rst", rdv[7:0], DMACFG_RST);
      rd(PMODE_OFS); check("pmode rst", rdv[1:0], PMODE_RST);
      rd(STATUS_OFS); check("enh rst", rdv[0], 0);
      $display("reset test done");
      foreach (rows[k]) begin
         wr(rows[k].a, {24'h0, rows[k].d});
         rd(rows[k].a);
         check("reg read", {erv, rdv[7:0]}, {rows[k].e, rows[k].x});
      end
      $display("register rows done");
      for (int m = 0; m < 3; m++) begin
         wr(CLKDIV_OFS, (m == 2) ? 32'h80 : 32'h0);
         wr(DMACFG_OFS, (m == 1) ? 32'h20 : 32'h0);
         wr(INTSTAT_OFS, 32'h7f);
         repeat (2) @(posedge core_clk);
         check("oe idle", int_b_oe, 0);
         usb_sof <= 1'b1;
         @(posedge core_clk);
         usb_sof <= 1'b0;
         repeat (3) @(posedge core_clk);
         check("oe sof", int_b_oe, m != 0);
         wr(INTSTAT_OFS, 32'h7f);
         usb_send(3'h2, 1, 8'h00);
         repeat (3) @(posedge core_clk);
         check("oe reg", int_b_oe, m != 2);
      end
      wr(CLKDIV_OFS, 32'h0);
      wr(DMACFG_OFS, 32'h0);
      $display("interrupt modes done");
      usb_send(PRI_OUT_IDX, 3, 8'h10);
      usb_send(PRI_OUT_IDX, 2, 8'h20);
      repeat (2) @(posedge core_clk);
      rd(STATUS_OFS); check("out full", rdv[2:1], 2'b11);
      rd(INTSTAT_OFS); check("out event", rdv[4], 1);
      for (int i = 0; i < 5; i++) begin
         rd(DATA_OFS); check("out byte", rdv[7:0], (i < 3) ? 8'h10 + i : 8'h1d + i);
      end
      rd(STATUS_OFS); check("out empty", rdv[2:1], 2'b00);
      $display("out path done");
      in_get(PRI_IN_IDX, 0, 8'h00, 1'b1);
      wr(DATA_OFS, 32'h30);
      wr(DATA_OFS, 32'h31);
      wr(CMD_OFS, {24'h0, VALIDATE_CMD});
      wr(DATA_OFS, 32'h40);
      wr(CMD_OFS, {24'h0, VALIDATE_CMD});
      in_get(PRI_OUT_IDX, 0, 8'h00, 1'b1);
      in_get(PRI_IN_IDX, 2, 8'h30, 1'b0);
      in_get(PRI_IN_IDX, 1, 8'h40, 1'b0);
      in_get(PRI_IN_IDX, 0, 8'h00, 1'b1);
      $display("in path done");
      for (int b = 0; b < 2; b++) begin
         usb_send(PRI_OUT_IDX, 4, 8'h50 + 8'(b));
         wr(DMACFG_OFS, 32'h3 | (b << 2));
         slow <= b[0];
         run <= 1'b1;
         rd(DATA_OFS); check("data blocked", rdv, 0);
         while (cnt < 4 * (b + 1)) @(posedge core_clk);
         run <= 1'b0;
         check("dma out", last_rd, 8'h53 + b);
         repeat (10) @(posedge core_clk);
         wr(DMACFG_OFS, 32'h0);
      end
      wr(DMACFG_OFS, 32'h1);
      run <= 1'b1;
      while (cnt < 72) @(posedge core_clk);
      run <= 1'b0;
      repeat (10) @(posedge core_clk);
      wr(DMACFG_OFS, 32'h0);
      in_get(PRI_IN_IDX, 64, 8'h88, 1'b0);
      $display("dma done");
      wr(CMD_OFS, 32'haf); rd(STATUS_OFS); check("enh below", rdv[0], 0);
      wr(CMD_OFS, 32'hbf); rd(STATUS_OFS); check("enh top", rdv[0], 1);
      do_reset();
      rd(STATUS_OFS); check("enh reset", rdv[0], 0);
      wr(CMD_OFS, 32'hb0); rd(STATUS_OFS); check("enh base", rdv[0], 1);
      $display("mode switch done");
      final_report();
   end
endmodule // tb_usb_endpoint_buffer_manager
`default_nettype wire

// [verilog/ebm_buffer_mgr.sv]
// Function
// - Two config bits select interrupt mode.
// - Interrupt from register bits, SOF, or both.
// - Mode 0 bits, 1 both, 2 SOF.
// - Default mode after every reset.
// - Commands B0h-BFh switch to enhanced mode.
// - Default mode has three bidirectional endpoints.
// - Control endpoint 16 bytes each way.
// - Auxiliary endpoint bulk/interrupt, 16 bytes.
// - Primary endpoint OUT index 4, IN 5.
// - Primary endpoint four modes set by setup.
// - Primary endpoint is double buffered.
// - Banks switch automatically; full bank readable.
// - DMA writes IN, reads OUT alone.
// - DMA single-cycle and burst transfers.
// - Host OUT data kept for local removal.
// - IN data released only on host request.
`timescale 1ns/1ps
`default_nettype none
module ebm_buffer_mgr
   import ebm_pkg::*;
(
   // Clock and reset.
   input wire logic core_clk,
   input wire logic rst_b,
   // APB slave.
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Host OUT stream from the protocol engine.
   input wire logic usb_out_valid,
   input wire logic [2:0] usb_out_idx,
   input wire logic [7:0] usb_out_data,
   input wire logic usb_out_last,
   output logic usb_out_ready,
   // Host IN requests and stream to the protocol engine.
   input wire logic usb_in_req,
   input wire logic [2:0] usb_in_idx,
   output logic usb_in_valid,
   output logic [7:0] usb_in_data,
   output logic usb_in_last,
   input wire logic usb_in_ready,
   output logic usb_in_nak,
   // Start-of-frame pulse.
   input wire logic usb_sof,
   // DMA pins.
   output logic dma_req,
   input wire logic dma_ack_b,
   input wire logic [7:0] dma_wdata,
   output logic [7:0] dma_rdata,
   // Open-drain interrupt pin.
   output logic int_b_o,
   output logic int_b_oe
);

   ////////////////////////////////////////////////////////////////////////////
   // Packet size per endpoint index and primary endpoint mode; zero disables.
   function automatic logic [7:0] mps(input logic [2:0] idx, input logic [1:0] m);
      logic [7:0] r;
      r = 8'h00;
      if (idx == 3'h0 || idx == 3'h1) begin
         r = CTRL_MPS;
      end else if (idx == 3'h2 || idx == 3'h3) begin
         r = AUX_MPS;
      end else if (idx == PRI_OUT_IDX) begin
         r = (m == 2'h0 || m == 2'h3) ? PRI_MPS : (m == 2'h1) ? PRI_ISO_MPS : 8'h00;
      end else if (idx == PRI_IN_IDX) begin
         r = (m == 2'h0 || m == 2'h3) ? PRI_MPS : (m == 2'h2) ? PRI_ISO_MPS : 8'h00;
      end
      return r;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // State.
   logic [7:0] clkdiv_q, clkdiv_d; // Frame-only bit lives here.
   logic [7:0] dmacfg_q, dmacfg_d; // DMA and merge bits.
   logic [1:0] pmode_q, pmode_d; // Primary endpoint mode.
   logic enh_q, enh_d; // Enhanced command set active.
   logic [6:0] ints_q, ints_d; // Pending endpoint events and SOF.
   logic [1:0] ofull_q, ofull_d; // OUT bank holds a packet.
   logic [7:0] olen_q [2], olen_d [2]; // OUT packet lengths.
   logic owb_q, owb_d, orb_q, orb_d; // OUT write and read banks.
   logic [7:0] owc_q, owc_d, orp_q, orp_d; // OUT counts.
   logic [1:0] ifull_q, ifull_d; // IN bank committed.
   logic [7:0] ilen_q [2], ilen_d [2]; // IN packet lengths.
   logic ilb_q, ilb_d, ihb_q, ihb_d; // Local fill and host banks.
   logic [7:0] ilp_q, ilp_d, isp_q, isp_d; // IN counts.
   ebm_in_state_t ist_q, ist_d; // Host IN sender.
   ebm_byte_t e0_q, e0_d, e1_q, e1_d; // Two-entry skid buffer.
   logic v0_q, v0_d, v1_q, v1_d;
   logic [31:0] prdata_q, prdata_d;
   logic pready_q, pready_d, pslverr_q, pslverr_d;
   logic oready_q, oready_d, nak_q, nak_d;
   logic dreq_q, dreq_d, oe_q, oe_d;
   logic [7:0] drd_q, drd_d;
   logic ack_s1_q, ack_s2_q, ack_s3_q; // Ack synchroniser and edge stage.
   logic [7:0] dw_s1_q, dw_s2_q; // DMA write data synchroniser.
   // Buffers: bank in the top address bit.
   logic [7:0] omem [BUF_DEPTH];
   logic [7:0] imem [BUF_DEPTH];

   ////////////////////////////////////////////////////////////////////////////
   // Combinational helpers.
   logic acc, wr, rd, dma_en, dma_stb, lpop, lpush, opush, spush, spop, int_act;
   logic [7:0] lbyte, ombyte, mps_o, mps_i;
   assign acc = psel & penable & pready_q;
   assign wr = acc & pwrite;
   assign rd = acc & ~pwrite;
   assign dma_en = dmacfg_q[DMA_EN_BIT];
   // Falling ack seen only past the second synchroniser flop.
   assign dma_stb = dma_en & ack_s3_q & ~ack_s2_q;
   assign mps_o = mps(PRI_OUT_IDX, pmode_q);
   assign mps_i = mps(PRI_IN_IDX, pmode_q);
   assign ombyte = omem[{orb_q, orp_q[6:0]}];
   assign lpop = ofull_q[orb_q] & (dma_en ? dma_stb & dmacfg_q[DMA_DIR_BIT] : rd & paddr == DATA_OFS);
   assign lpush = ~ifull_q[ilb_q] & mps_i != 8'h00
                  & (dma_en ? dma_stb & ~dmacfg_q[DMA_DIR_BIT] : wr & paddr == DATA_OFS);
   assign lbyte = dma_en ? dw_s2_q : pwdata[7:0];
   assign opush = usb_out_valid & oready_q & usb_out_idx == PRI_OUT_IDX & owc_q < mps_o;
   assign spush = ist_q == IS_SEND & ~v1_q;
   assign spop = v0_q & usb_in_ready;
   always_comb begin
      if (clkdiv_q[SOF_ONLY_BIT]) begin
         int_act = ints_q[SOF_PEND_BIT];
      end else if (dmacfg_q[MERGE_BIT]) begin
         int_act = |ints_q;
      end else begin
         int_act = |ints_q[5:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Registers, APB answer and interrupt flags.
   always_comb begin
      clkdiv_d = clkdiv_q;
      dmacfg_d = dmacfg_q;
      pmode_d = pmode_q;
      enh_d = enh_q;
      ints_d = ints_q;
      prdata_d = prdata_q;
      pslverr_d = 1'b0;
      // One wait state: ready rises in the second access cycle.
      pready_d = psel & penable & ~pready_q;
      if (psel & penable & ~pready_q) begin
         prdata_d = 32'h0000_0000;
         unique case (paddr)
            CLKDIV_OFS: prdata_d[7:0] = clkdiv_q;
            DMACFG_OFS: prdata_d[7:0] = dmacfg_q;
            CMD_OFS: prdata_d = 32'h0000_0000;
            PMODE_OFS: prdata_d[1:0] = pmode_q;
            INTSTAT_OFS: prdata_d[6:0] = ints_q;
            STATUS_OFS: prdata_d[6:0] = {ilb_q, orb_q, ifull_q, ofull_q, enh_q};
            // DMA owns the data path, so a processor read sees zero.
            DATA_OFS: prdata_d[7:0] = ofull_q[orb_q] & ~dma_en ? ombyte : 8'h00;
            default: pslverr_d = 1'b1; // Unmapped address.
         endcase
      end
      if (wr) begin
         unique case (paddr)
            CLKDIV_OFS: clkdiv_d = pwdata[7:0];
            DMACFG_OFS: dmacfg_d = pwdata[7:0];
            PMODE_OFS: pmode_d = pwdata[1:0];
            INTSTAT_OFS: ints_d = ints_q & ~pwdata[6:0];
            CMD_OFS: enh_d = enh_q | (pwdata[7:0] >= ENH_LO & pwdata[7:0] <= ENH_HI);
            default: ;
         endcase
      end
      // event sources; a set beats a clear in the same cycle.
      if (usb_sof) begin
         ints_d[SOF_PEND_BIT] = 1'b1;
      end
      // Indices above the primary IN endpoint have no flag and are ignored.
      if (usb_out_valid & oready_q & usb_out_last & usb_out_idx <= PRI_IN_IDX) begin
         ints_d[usb_out_idx] = 1'b1;
      end
      if (spush & isp_q + 8'h01 >= ilen_q[ihb_q]) begin
         ints_d[PRI_IN_IDX] = 1'b1;
      end
      oe_d = int_act;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Primary OUT double buffer.
   always_comb begin
      ofull_d = ofull_q;
      olen_d = olen_q;
      owb_d = owb_q;
      orb_d = orb_q;
      owc_d = owc_q;
      orp_d = orp_q;
      if (opush) begin
         owc_d = owc_q + 8'h01;
      end
      if (usb_out_valid & oready_q & usb_out_idx == PRI_OUT_IDX & usb_out_last) begin
         ofull_d[owb_q] = 1'b1;
         olen_d[owb_q] = owc_d;
         owb_d = ~owb_q;
         owc_d = 8'h00;
      end
      if (lpop) begin
         orp_d = orp_q + 8'h01;
         if (orp_q + 8'h01 >= olen_q[orb_q]) begin
            ofull_d[orb_q] = 1'b0;
            orb_d = ~orb_q;
            orp_d = 8'h00;
         end
      end
      oready_d = ~ofull_d[owb_d];
   end

   ////////////////////////////////////////////////////////////////////////////
   // Primary IN double buffer and host sender.
   always_comb begin
      ifull_d = ifull_q;
      ilen_d = ilen_q;
      ilb_d = ilb_q;
      ihb_d = ihb_q;
      ilp_d = ilp_q;
      isp_d = isp_q;
      ist_d = ist_q;
      nak_d = 1'b0;
      if (lpush) begin
         ilp_d = ilp_q + 8'h01;
      end
      // A full bank or a validate command commits the packet.
      if ((lpush & ilp_d >= mps_i) | (wr & paddr == CMD_OFS & pwdata[7:0] == VALIDATE_CMD
          & ~ifull_q[ilb_q] & ilp_q != 8'h00)) begin
         ifull_d[ilb_q] = 1'b1;
         ilen_d[ilb_q] = ilp_d;
         ilb_d = ~ilb_q;
         ilp_d = 8'h00;
      end
      unique case (ist_q)
         IS_IDLE: begin
            if (usb_in_req) begin
               if (usb_in_idx == PRI_IN_IDX & ifull_q[ihb_q]) begin
                  ist_d = IS_SEND;
                  isp_d = 8'h00;
               end else begin
                  nak_d = 1'b1;
               end
            end
         end
         IS_SEND: begin
            if (spush) begin
               isp_d = isp_q + 8'h01;
               if (isp_q + 8'h01 >= ilen_q[ihb_q]) begin
                  ifull_d[ihb_q] = 1'b0;
                  ihb_d = ~ihb_q;
                  ist_d = IS_IDLE;
               end
            end
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // Two-entry skid buffer toward the host; a stall holds the sender.
   always_comb begin
      e0_d = e0_q;
      e1_d = e1_q;
      v0_d = v0_q;
      v1_d = v1_q;
      if (spop) begin
         e0_d = e1_q;
         v0_d = v1_q;
         v1_d = 1'b0;
      end
      if (spush) begin
         if (v0_d) begin
            e1_d = '{last: isp_q + 8'h01 >= ilen_q[ihb_q], data: imem[{ihb_q, isp_q[6:0]}]};
            v1_d = 1'b1;
         end else begin
            e0_d = '{last: isp_q + 8'h01 >= ilen_q[ihb_q], data: imem[{ihb_q, isp_q[6:0]}]};
            v0_d = 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // DMA request and read data.
   always_comb begin
      drd_d = lpop & dma_en ? ombyte : drd_q;
      // burst keeps asking; single-cycle waits out the ack.
      dreq_d = dma_en & (dmacfg_q[DMA_DIR_BIT] ? ofull_q[orb_q] : ~ifull_q[ilb_q] & mps_i != 8'h00)
               & (dmacfg_q[DMA_BURST_BIT] | ack_s2_q) & ~dma_stb;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Buffer memories; no reset since the full flags guard them.
   always_ff @(posedge core_clk) begin
      if (opush) begin
         omem[{owb_q, owc_q[6:0]}] <= usb_out_data;
      end
      if (lpush) begin
         imem[{ilb_q, ilp_q[6:0]}] <= lbyte;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // All control flops.
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         clkdiv_q <= CLKDIV_RST;
         dmacfg_q <= DMACFG_RST;
         pmode_q <= PMODE_RST;
         enh_q <= 1'b0;
         ints_q <= 7'h00;
         ofull_q <= 2'h0;
         olen_q <= '{8'h00, 8'h00};
         owb_q <= 1'b0;
         orb_q <= 1'b0;
         owc_q <= 8'h00;
         orp_q <= 8'h00;
         ifull_q <= 2'h0;
         ilen_q <= '{8'h00, 8'h00};
         ilb_q <= 1'b0;
         ihb_q <= 1'b0;
         ilp_q <= 8'h00;
         isp_q <= 8'h00;
         ist_q <= IS_IDLE;
         e0_q <= '0;
         e1_q <= '0;
         v0_q <= 1'b0;
         v1_q <= 1'b0;
         prdata_q <= 32'h0000_0000;
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         oready_q <= 1'b1;
         nak_q <= 1'b0;
         dreq_q <= 1'b0;
         oe_q <= 1'b0;
         drd_q <= 8'h00;
         ack_s1_q <= 1'b1;
         ack_s2_q <= 1'b1;
         ack_s3_q <= 1'b1;
         dw_s1_q <= 8'h00;
         dw_s2_q <= 8'h00;
      end else begin
         clkdiv_q <= clkdiv_d;
         dmacfg_q <= dmacfg_d;
         pmode_q <= pmode_d;
         enh_q <= enh_d;
         ints_q <= ints_d;
         ofull_q <= ofull_d;
         olen_q <= olen_d;
         owb_q <= owb_d;
         orb_q <= orb_d;
         owc_q <= owc_d;
         orp_q <= orp_d;
         ifull_q <= ifull_d;
         ilen_q <= ilen_d;
         ilb_q <= ilb_d;
         ihb_q <= ihb_d;
         ilp_q <= ilp_d;
         isp_q <= isp_d;
         ist_q <= ist_d;
         e0_q <= e0_d;
         e1_q <= e1_d;
         v0_q <= v0_d;
         v1_q <= v1_d;
         prdata_q <= prdata_d;
         pready_q <= pready_d;
         pslverr_q <= pslverr_d;
         oready_q <= oready_d;
         nak_q <= nak_d;
         dreq_q <= dreq_d;
         oe_q <= oe_d;
         drd_q <= drd_d;
         ack_s1_q <= dma_ack_b;
         ack_s2_q <= ack_s1_q;
         ack_s3_q <= ack_s2_q;
         dw_s1_q <= dma_wdata;
         dw_s2_q <= dw_s1_q;
      end
   end

   // Outputs straight from flops except int_b_o, which is tied low; the open-drain pin only ever pulls low.
   assign prdata = prdata_q;
   assign pready = pready_q;
   assign pslverr = pslverr_q;
   assign usb_out_ready = oready_q;
   assign usb_in_valid = v0_q;
   assign usb_in_data = e0_q.data;
   assign usb_in_last = e0_q.last;
   assign usb_in_nak = nak_q;
   assign dma_req = dreq_q;
   assign dma_rdata = drd_q;
   assign int_b_o = 1'b0;
   assign int_b_oe = oe_q;

   ////////////////////////////////////////////////////////////////////////////
   // Checks.
   property p_sof_only;
      @(posedge core_clk) disable iff (!rst_b)
      clkdiv_q[SOF_ONLY_BIT] & ~ints_q[SOF_PEND_BIT] |=> ~int_b_oe;
   endproperty
   a_sof_only: assert property (p_sof_only) else $error("SOF-only mode drove pin without SOF");
   property p_mode0;
      @(posedge core_clk) disable iff (!rst_b)
      ~clkdiv_q[SOF_ONLY_BIT] & ~dmacfg_q[MERGE_BIT] & ints_q == 7'h40 |=> ~int_b_oe;
   endproperty
   a_mode0: assert property (p_mode0) else $error("Mode 0 reacted to SOF");
   property p_merge;
      @(posedge core_clk) disable iff (!rst_b)
      ~clkdiv_q[SOF_ONLY_BIT] & dmacfg_q[MERGE_BIT] & ints_q[SOF_PEND_BIT] |=> int_b_oe;
   endproperty
   a_merge: assert property (p_merge) else $error("Mode 1 missed SOF");
   property p_pin;
      @(posedge core_clk) disable iff (!rst_b)
      ints_q == 7'h00 ##1 ints_q == 7'h00 |-> ~int_b_oe;
   endproperty
   a_pin: assert property (p_pin) else $error("Pin low with nothing pending");
   property p_enh;
      @(posedge core_clk) disable iff (!rst_b)
      $rose(enh_q) |-> $past(wr & paddr == CMD_OFS & pwdata[7:4] == 4'hb);
   endproperty
   a_enh: assert property (p_enh) else $error("Enhanced mode without layout command");
   property p_enh_hold;
      @(posedge core_clk) disable iff (!rst_b)
      enh_q |=> enh_q;
   endproperty
   a_enh_hold: assert property (p_enh_hold) else $error("Enhanced mode dropped without reset");
   property p_nak;
      @(posedge core_clk) disable iff (!rst_b)
      ist_q == IS_IDLE & usb_in_req & ~ifull_q[ihb_q] |=> usb_in_nak ##1 ~usb_in_nak;
   endproperty
   a_nak: assert property (p_nak) else $error("Empty IN request not refused");
   property p_out_bank;
      @(posedge core_clk) disable iff (!rst_b)
      usb_out_valid & oready_q & usb_out_idx == PRI_OUT_IDX & usb_out_last
      |=> ofull_q[$past(owb_q)] & owb_q != $past(owb_q);
   endproperty
   a_out_bank: assert property (p_out_bank) else $error("OUT bank not closed and switched");
   property p_dma_push;
      @(posedge core_clk) disable iff (!rst_b)
      dma_stb & ~dmacfg_q[DMA_DIR_BIT] & ~ifull_q[ilb_q] & mps_i != 8'h00
      |=> ilp_q != $past(ilp_q) | ilb_q != $past(ilb_q);
   endproperty
   a_dma_push: assert property (p_dma_push) else $error("DMA byte not stored");
endmodule // ebm_buffer_mgr
`default_nettype wire

// [verilog/ebm_pkg.sv]
`default_nettype none
// Shared constants and types of the endpoint buffer manager.
package ebm_pkg;
   // APB register byte offsets.
   localparam logic [7:0] CLKDIV_OFS = 8'h00;
   localparam logic [7:0] DMACFG_OFS = 8'h04;
   localparam logic [7:0] CMD_OFS = 8'h08;
   localparam logic [7:0] PMODE_OFS = 8'h0c;
   localparam logic [7:0] INTSTAT_OFS = 8'h10;
   localparam logic [7:0] STATUS_OFS = 8'h14;
   localparam logic [7:0] DATA_OFS = 8'h18;
   // Register values after reset.
   localparam logic [7:0] CLKDIV_RST = 8'h00;
   localparam logic [7:0] DMACFG_RST = 8'h00;
   localparam logic [1:0] PMODE_RST = 2'h0;
   // Field positions.
   localparam int SOF_ONLY_BIT = 7;
   localparam int MERGE_BIT = 5;
   localparam int DMA_EN_BIT = 0;
   localparam int DMA_DIR_BIT = 1;
   localparam int DMA_BURST_BIT = 2;
   localparam int SOF_PEND_BIT = 6;
   // Command codes.
   localparam logic [7:0] ENH_LO = 8'hb0;
   localparam logic [7:0] ENH_HI = 8'hbf;
   localparam logic [7:0] VALIDATE_CMD = 8'hfa;
   // Endpoint indices and packet sizes.
   localparam logic [2:0] PRI_OUT_IDX = 3'h4;
   localparam logic [2:0] PRI_IN_IDX = 3'h5;
   localparam logic [7:0] CTRL_MPS = 8'h10;
   localparam logic [7:0] AUX_MPS = 8'h10;
   localparam logic [7:0] PRI_MPS = 8'h40;
   localparam logic [7:0] PRI_ISO_MPS = 8'h80;
   localparam int BUF_DEPTH = 256;
   // One byte on its way to the host.
   typedef struct packed {
      logic last;
      logic [7:0] data;
   } ebm_byte_t;
   // Host IN sender states.
   typedef enum logic [1:0] {
      IS_IDLE = 2'b01,
      IS_SEND = 2'b10
   } ebm_in_state_t;
endpackage
`default_nettype wire
